// ==== hw/scp_pkg.sv ====
// package for the scan-port connect controller: pin layout, dedicated
// addresses, tap and connect-status encodings, carrier structs.
// assumes one 20 MHz clock samples every pin, the test clock among them.
package scp_pkg;

  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] RESET_ADDR = 10'h000;
  localparam logic [ADDR_W-1:0] DISCONNECT_ADDR = 10'h3fe;
  localparam logic [ADDR_W-1:0] TEST_SYNC_ADDR = 10'h3ff;

  // bit positions in the sampled pin vector
  localparam int PIN_PDI = 0;
  localparam int PIN_PMS = 1;
  localparam int PIN_PCK = 2;
  localparam int PIN_PRST = 3;
  localparam int PIN_SDI = 4;
  localparam int PIN_BYP = 5;
  localparam int PIN_ADDR = 6;
  localparam int PIN_W = PIN_ADDR + ADDR_W;
  // pin vector value after reset: test reset and bypass inactive (high)
  localparam logic [PIN_W-1:0] PIN_RESET = 16'h0028;

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SHIFT_DR = 4'h4, TAP_EXIT1_DR = 4'h5, TAP_PAUSE_DR = 4'h6, TAP_EXIT2_DR = 4'h7,
    TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SHIFT_IR = 4'hb,
    TAP_EXIT1_IR = 4'hc, TAP_PAUSE_IR = 4'hd, TAP_EXIT2_IR = 4'he, TAP_UPD_IR = 4'hf
  } scp_tap_t;

  typedef enum logic [1:0] {
    CS_OFF = 2'h0,
    CS_ON = 2'h1,
    CS_RESET = 2'h2,
    CS_MCAST = 2'h3
  } scp_conn_t;

  typedef struct packed {
    logic addrValid;
    logic [ADDR_W-1:0] addr;
    logic ackBit;
    logic ackDone;
  } scp_rx_in_t;

  typedef struct packed {
    logic rxHold;
    logic selEnable;
    logic ackActive;
  } scp_rx_out_t;

  function automatic scp_tap_t scp_tap_next(input scp_tap_t s, input logic tms);
    unique case (s)
      TAP_RESET: scp_tap_next = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: scp_tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: scp_tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: scp_tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: scp_tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: scp_tap_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: scp_tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: scp_tap_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: scp_tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: scp_tap_next = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: scp_tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: scp_tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: scp_tap_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: scp_tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: scp_tap_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: scp_tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
  endfunction : scp_tap_next

endpackage : scp_pkg

// ==== hw/scp_connect_ctrl.sv ====
// connect-status controller of a multidrop addressable scan port.
// assumes a separate select receiver and acknowledge sender on the same clock
// hand over decoded addresses and acknowledge bits; all pins are asynchronous.

module scp_connect_ctrl #(
  parameter int ADDR_W = scp_pkg::ADDR_W
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic primaryDataIn,
  input wire logic primaryModeSelect,
  input wire logic primaryTestClock,
  input wire logic primaryTestReset_b,
  input wire logic secondaryDataIn,
  input wire logic protocolBypassIn_b,
  input wire logic [ADDR_W-1:0] boardAddressInputs,
  input wire scp_pkg::scp_rx_in_t rxIn,
  output logic primaryDataOut,
  output logic primaryDataOutEn,
  output logic secondaryDataOut,
  output logic secondaryDataOutEn,
  output logic secondaryModeSelect,
  output logic secondaryTestClock,
  output logic secondaryTestReset_b,
  output logic connectIndicator_b,
  output scp_pkg::scp_rx_out_t rxOut
);

  typedef struct packed {
    logic [scp_pkg::PIN_W-1:0] s1;
    logic [scp_pkg::PIN_W-1:0] s2;
    logic [scp_pkg::PIN_W-1:0] s3;
    logic [scp_pkg::PIN_W-1:0] lvl;
    scp_pkg::scp_tap_t prim;
    scp_pkg::scp_tap_t sec;
    scp_pkg::scp_conn_t conn;
    logic ackBusy;
    logic pdo;
    logic pdoEn;
    logic sdo;
    logic sdoEn;
    logic sms;
    logic secondary_test_clock;
    logic strstB;
    logic conB;
    scp_pkg::scp_rx_out_t rxo;
  } scp_state_t;

  scp_state_t state_r;
  scp_state_t state_nxt;
  logic [scp_pkg::PIN_W-1:0] pinIn;
  logic bypOn;
  logic trstOn;
  logic selEnable;
  logic accept;
  logic tckRise;
  logic isReset;
  logic isDisc;
  logic isSync;
  logic isMatch;
  logic bothPaused;

  assign pinIn = {boardAddressInputs, protocolBypassIn_b, secondaryDataIn,
                  primaryTestReset_b, primaryTestClock, primaryModeSelect, primaryDataIn};

  // bypass and test reset act from the filtered levels; the sampled clock
  // rides through the same stages so data keeps its place against it
  assign bypOn = !state_r.lvl[scp_pkg::PIN_BYP];
  assign trstOn = !state_r.lvl[scp_pkg::PIN_PRST];
  assign tckRise = state_r.lvl[scp_pkg::PIN_PCK] && !state_r.secondary_test_clock;

  assign selEnable = !bypOn && !trstOn &&
                     (state_r.prim == scp_pkg::TAP_RESET || state_r.prim == scp_pkg::TAP_IDLE ||
                      state_r.prim == scp_pkg::TAP_PAUSE_DR ||
                      state_r.prim == scp_pkg::TAP_PAUSE_IR);
  assign accept = rxIn.addrValid && selEnable;

  assign isReset = rxIn.addr == scp_pkg::RESET_ADDR;
  assign isDisc = rxIn.addr == scp_pkg::DISCONNECT_ADDR;
  assign isSync = rxIn.addr == scp_pkg::TEST_SYNC_ADDR;
  assign isMatch = !isReset && !isDisc && !isSync &&
                   rxIn.addr == state_r.lvl[scp_pkg::PIN_ADDR +: ADDR_W];
  assign bothPaused = (state_r.prim == scp_pkg::TAP_PAUSE_DR ||
                       state_r.prim == scp_pkg::TAP_PAUSE_IR) &&
                      (state_r.sec == scp_pkg::TAP_PAUSE_DR ||
                       state_r.sec == scp_pkg::TAP_PAUSE_IR);

  always_comb begin
    state_nxt = state_r;
    // first stage feeds only the second; a level counts once stages two and three agree
    state_nxt.s1 = pinIn;
    state_nxt.s2 = state_r.s1;
    state_nxt.s3 = state_r.s2;
    state_nxt.lvl = (state_r.s2 & state_r.s3) | (state_r.lvl & (state_r.s2 ^ state_r.s3));

    // protocol results; bypass alone leaves status untouched, test reset clears it even in bypass
    if (trstOn) begin
      state_nxt.conn = scp_pkg::CS_OFF;
      state_nxt.ackBusy = 1'b0;
    end else if (accept) begin
      state_nxt.ackBusy = 1'b0;
      if (isReset) begin
        state_nxt.conn = scp_pkg::CS_RESET;
      end else if (isSync && bothPaused) begin
        state_nxt.conn = scp_pkg::CS_MCAST;
      end else if (isMatch) begin
        state_nxt.ackBusy = 1'b1;
      end else begin
        state_nxt.conn = scp_pkg::CS_OFF;
      end
    end else if (state_r.ackBusy && rxIn.ackDone && !bypOn) begin
      state_nxt.conn = scp_pkg::CS_ON;
      state_nxt.ackBusy = 1'b0;
    end

    // output selection
    state_nxt.pdo = 1'b0;
    state_nxt.pdoEn = 1'b0;
    state_nxt.sdo = 1'b0;
    state_nxt.sdoEn = 1'b0;
    state_nxt.sms = state_r.sms;
    state_nxt.conB = 1'b1;
    if (bypOn) begin
      // release falls back to kept status
      state_nxt.pdo = state_r.lvl[scp_pkg::PIN_SDI];
      state_nxt.pdoEn = 1'b1;
      state_nxt.sdo = state_r.lvl[scp_pkg::PIN_PDI];
      state_nxt.sdoEn = 1'b1;
      state_nxt.sms = trstOn | state_r.lvl[scp_pkg::PIN_PMS];
      state_nxt.conB = 1'b0;
    end else if (trstOn) begin
      state_nxt.sms = 1'b1;
    end else if (state_r.ackBusy) begin
      state_nxt.pdo = rxIn.ackBit;
      state_nxt.pdoEn = 1'b1;
    end else begin
      unique case (state_r.conn)
        scp_pkg::CS_ON: begin
          state_nxt.pdo = state_r.lvl[scp_pkg::PIN_SDI];
          state_nxt.pdoEn = 1'b1;
          state_nxt.sdo = state_r.lvl[scp_pkg::PIN_PDI];
          state_nxt.sdoEn = 1'b1;
          state_nxt.sms = state_r.lvl[scp_pkg::PIN_PMS];
          state_nxt.conB = 1'b0;
        end
        scp_pkg::CS_MCAST: begin
          state_nxt.sdo = state_r.lvl[scp_pkg::PIN_PDI];
          state_nxt.sdoEn = 1'b1;
          state_nxt.sms = state_r.lvl[scp_pkg::PIN_PMS];
          state_nxt.conB = 1'b0;
        end
        scp_pkg::CS_RESET: begin
          state_nxt.sms = 1'b1;
        end
        scp_pkg::CS_OFF: begin
          state_nxt.sms = state_r.sms;
        end
      endcase
    end

    state_nxt.strstB = state_r.lvl[scp_pkg::PIN_PRST];
    state_nxt.secondary_test_clock = state_r.lvl[scp_pkg::PIN_PCK];

    if (trstOn) begin
      state_nxt.prim = scp_pkg::TAP_RESET;
    end else if (tckRise) begin
      state_nxt.prim = scp_pkg::scp_tap_next(state_r.prim, state_r.lvl[scp_pkg::PIN_PMS]);
    end
    // the far chain sees the mode level launched with the clock edge
    if (trstOn) begin
      state_nxt.sec = scp_pkg::TAP_RESET;
    end else if (tckRise) begin
      state_nxt.sec = scp_pkg::scp_tap_next(state_r.sec, state_nxt.sms);
    end

    state_nxt.rxo.rxHold = bypOn | trstOn;
    state_nxt.rxo.selEnable = selEnable;
    state_nxt.rxo.ackActive = state_nxt.ackBusy;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= '0;
      state_r.s1 <= scp_pkg::PIN_RESET;
      state_r.s2 <= scp_pkg::PIN_RESET;
      state_r.s3 <= scp_pkg::PIN_RESET;
      state_r.lvl <= scp_pkg::PIN_RESET;
      state_r.prim <= scp_pkg::TAP_RESET;
      state_r.sec <= scp_pkg::TAP_RESET;
      state_r.conn <= scp_pkg::CS_OFF;
      state_r.sms <= 1'b1;
      state_r.strstB <= 1'b1;
      state_r.conB <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign primaryDataOut = state_r.pdo;
  assign primaryDataOutEn = state_r.pdoEn;
  assign secondaryDataOut = state_r.sdo;
  assign secondaryDataOutEn = state_r.sdoEn;
  assign secondaryModeSelect = state_r.sms;
  assign secondaryTestClock = state_r.secondary_test_clock;
  assign secondaryTestReset_b = state_r.strstB;
  assign connectIndicator_b = state_r.conB;
  assign rxOut = state_r.rxo;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_trst_pass: assert property (
    ##1 secondaryTestReset_b == $past(state_r.lvl[scp_pkg::PIN_PRST]))
    else $error("secondary reset does not follow primary reset");
  a_byp_con_low: assert property (
    bypOn |=> !connectIndicator_b && rxOut.rxHold)
    else $error("bypass did not drive indicator low");
  a_byp_data_path: assert property (
    bypOn |=> secondaryDataOutEn && primaryDataOutEn &&
              secondaryDataOut == $past(state_r.lvl[scp_pkg::PIN_PDI]))
    else $error("bypass data path not connected");
  a_byp_trst_sms: assert property (
    (bypOn || trstOn) && trstOn |=> secondaryModeSelect)
    else $error("mode-select not high under test reset");
  a_trst_hold: assert property (
    !bypOn && trstOn |=> connectIndicator_b && !primaryDataOutEn && !secondaryDataOutEn)
    else $error("reset hold status wrong");
  a_rx_held: assert property (
    bypOn |-> !accept ##1 !rxOut.selEnable)
    else $error("select accepted during bypass");
  a_reset_addr: assert property (
    accept && isReset |=> state_r.conn == scp_pkg::CS_RESET && !state_r.ackBusy
                      ##1 (secondaryModeSelect || bypOn))
    else $error("reset address did not give reset status");
  a_match_ack: assert property (
    accept && isMatch |=> state_r.ackBusy ##1 (rxOut.ackActive || !state_r.ackBusy))
    else $error("match did not start acknowledge");
  a_ack_then_on: assert property (
    state_r.ackBusy && rxIn.ackDone && !trstOn && !bypOn && !accept
      |=> state_r.conn == scp_pkg::CS_ON ##1
          (!connectIndicator_b || state_r.ackBusy || bypOn || trstOn))
    else $error("acknowledge end did not give on status");
  a_nomatch_off: assert property (
    accept && !isMatch && !isReset && !(isSync && bothPaused)
      |=> state_r.conn == scp_pkg::CS_OFF && !state_r.ackBusy)
    else $error("non-matching address did not give off status");
  a_sync_gate: assert property (
    accept && isSync && !bothPaused |=> state_r.conn != scp_pkg::CS_MCAST)
    else $error("sync address honoured outside pause");
  a_con_ack: assert property (
    state_r.ackBusy && !bypOn |=> connectIndicator_b)
    else $error("indicator low during acknowledge");
  a_mcast_path: assert property (
    state_r.conn == scp_pkg::CS_MCAST && !state_r.ackBusy && !bypOn && !trstOn
      |=> !primaryDataOutEn && secondaryDataOutEn &&
          secondaryModeSelect == $past(state_r.lvl[scp_pkg::PIN_PMS]))
    else $error("multicast paths wrong");

  c_match_on: cover property (state_r.ackBusy ##1 state_r.conn == scp_pkg::CS_ON);
  c_multicast: cover property (accept && isSync && bothPaused);
  c_bypass: cover property (bypOn ##1 !bypOn);
  c_reset_addr: cover property (accept && isReset);
  c_trst_byp: cover property (trstOn && bypOn);

endmodule : scp_connect_ctrl

// ==== test/scp_ctrl_model.sv ====
// backplane controller model that drives the primary test port.
// assumes the system clock is supplied; every change lands on its falling edge.
module scp_ctrl_model (
  input wire logic clock,
  output logic primaryTestClock,
  output logic primaryModeSelect,
  output logic primaryDataIn
);
  timeunit 1ns;
  timeprecision 1ns;

  // the test clock stands still low between steps, as a real controller would leave it
  initial begin
    primaryTestClock = 1'b0;
    primaryModeSelect = 1'b0;
    primaryDataIn = 1'b1;
  end

  // mode held steady
  // mode changes only with the test clock low, once per 450 ns step
  task automatic tapStep(input logic ms);
    @(negedge clock);
    primaryModeSelect = ms;
    repeat (4) @(negedge clock);
    primaryTestClock = 1'b1;
    repeat (4) @(negedge clock);
    primaryTestClock = 1'b0;
  endtask : tapStep

  // harmless data
  // data only moves on request, so no stray protocol builds up
  task automatic setData(input logic d);
    @(negedge clock);
    primaryDataIn = d;
  endtask : setData
endmodule : scp_ctrl_model

// ==== test/tb.sv ====
// self-checking bench for the scan-port connect controller.
// assumes the select receiver is stood in for by the bench through rxIn.
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [9:0] BOARD = 10'h2a5;
  localparam logic [9:0] NEW_BOARD = 10'h0c3;
  logic [9:0] boardAddr;
  localparam logic [9:0] OFF_CODES [3] = '{scp_pkg::DISCONNECT_ADDR, scp_pkg::TEST_SYNC_ADDR,
    10'h155};
  logic clock, rst_b, primaryTestReset_b, secondaryDataIn, protocolBypassIn_b;
  logic primaryDataIn, primaryModeSelect, primaryTestClock;
  logic primaryDataOut, primaryDataOutEn, secondaryDataOut, secondaryDataOutEn;
  logic secondaryModeSelect, secondaryTestClock, secondaryTestReset_b, connectIndicator_b;
  scp_pkg::scp_rx_in_t rxIn;
  scp_pkg::scp_rx_out_t rxOut;
  int fails = 0;
  int checksDone = 0;

  scp_ctrl_model i_scp_ctrl_model (.clock(clock), .primaryTestClock(primaryTestClock),
    .primaryModeSelect(primaryModeSelect), .primaryDataIn(primaryDataIn));

  scp_connect_ctrl i_scp_connect_ctrl (.clock(clock), .rst_b(rst_b),
    .primaryDataIn(primaryDataIn), .primaryModeSelect(primaryModeSelect),
    .primaryTestClock(primaryTestClock), .primaryTestReset_b(primaryTestReset_b),
    .secondaryDataIn(secondaryDataIn), .protocolBypassIn_b(protocolBypassIn_b),
    .boardAddressInputs(boardAddr), .rxIn(rxIn), .primaryDataOut(primaryDataOut),
    .primaryDataOutEn(primaryDataOutEn), .secondaryDataOut(secondaryDataOut),
    .secondaryDataOutEn(secondaryDataOutEn), .secondaryModeSelect(secondaryModeSelect),
    .secondaryTestClock(secondaryTestClock), .secondaryTestReset_b(secondaryTestReset_b),
    .connectIndicator_b(connectIndicator_b), .rxOut(rxOut));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task automatic sendAddr(input logic [9:0] a);
    @(negedge clock);
    rxIn.addrValid = 1'b1;
    rxIn.addr = a;
    @(negedge clock);
    rxIn.addrValid = 1'b0;
  endtask : sendAddr

  task automatic pulseDone();
    @(negedge clock);
    rxIn.ackDone = 1'b1;
    @(negedge clock);
    rxIn.ackDone = 1'b0;
  endtask : pulseDone

  task automatic connect();
    sendAddr(BOARD);
    cyc(2);
    pulseDone();
    cyc(8);
  endtask : connect

  task automatic testPowerUp();
    chk({connectIndicator_b, primaryDataOutEn, secondaryDataOutEn}, 3'h4);
    chk(secondaryTestReset_b, 1'b1);
  endtask : testPowerUp

  task automatic testDeselect();
    foreach (OFF_CODES[i]) begin
      connect();
      sendAddr(OFF_CODES[i]);
      cyc(3);
      chk({connectIndicator_b, primaryDataOutEn, secondaryDataOutEn, rxOut.ackActive,
        secondaryModeSelect}, 5'h10);
    end
    connect();
    sendAddr(scp_pkg::RESET_ADDR);
    cyc(3);
    chk({connectIndicator_b, primaryDataOutEn, secondaryDataOutEn, rxOut.ackActive,
      secondaryModeSelect}, 5'h11);
  endtask : testDeselect

  task automatic testMatch();
    sendAddr(BOARD);
    cyc(2);
    chk({rxOut.ackActive, primaryDataOutEn, primaryDataOut}, 3'h7);
    chk({connectIndicator_b, secondaryDataOutEn}, 2'h2);
    rxIn.ackBit = 1'b0;
    cyc(2);
    chk({rxOut.ackActive, primaryDataOutEn, primaryDataOut}, 3'h6);
    pulseDone();
    cyc(3);
    chk({connectIndicator_b, primaryDataOutEn, secondaryDataOutEn}, 3'h3);
    i_scp_ctrl_model.setData(1'b1);
    secondaryDataIn = 1'b0;
    cyc(7);
    chk({secondaryDataOut, primaryDataOut, secondaryModeSelect}, 3'h4);
    i_scp_ctrl_model.setData(1'b0);
    secondaryDataIn = 1'b1;
    cyc(7);
    chk({secondaryDataOut, primaryDataOut}, 2'h1);
  endtask : testMatch

  task automatic testMulticast();
    fork
      i_scp_ctrl_model.tapStep(1'b0);
      begin
        cyc(10);
        chk(secondaryTestClock, 1'b1);
      end
    join
    cyc(5);
    chk(secondaryTestClock, 1'b0);
    i_scp_ctrl_model.tapStep(1'b1);
    cyc(6);
    chk(rxOut.selEnable, 1'b0);
    i_scp_ctrl_model.tapStep(1'b0);
    i_scp_ctrl_model.tapStep(1'b1);
    i_scp_ctrl_model.tapStep(1'b0);
    cyc(8);
    chk(rxOut.selEnable, 1'b1);
    sendAddr(scp_pkg::TEST_SYNC_ADDR);
    cyc(3);
    chk({connectIndicator_b, primaryDataOutEn, secondaryDataOutEn, rxOut.ackActive},
      4'h2);
  endtask : testMulticast

  task automatic testBypass();
    protocolBypassIn_b = 1'b0;
    cyc(7);
    chk({connectIndicator_b, primaryDataOutEn, secondaryDataOutEn, rxOut.rxHold},
      4'h7);
    sendAddr(BOARD);
    cyc(3);
    chk(rxOut.ackActive, 1'b0);
    protocolBypassIn_b = 1'b1;
    cyc(7);
    chk({connectIndicator_b, primaryDataOutEn, secondaryDataOutEn, rxOut.rxHold},
      4'h2);
  endtask : testBypass

  task automatic testTestReset();
    primaryTestReset_b = 1'b0;
    cyc(7);
    chk({secondaryTestReset_b, connectIndicator_b, primaryDataOutEn, secondaryDataOutEn,
      secondaryModeSelect}, 5'h09);
    sendAddr(BOARD);
    cyc(3);
    chk(rxOut.ackActive, 1'b0);
    protocolBypassIn_b = 1'b0;
    cyc(7);
    chk({connectIndicator_b, secondaryDataOutEn, secondaryModeSelect}, 3'h3);
    protocolBypassIn_b = 1'b1;
    primaryTestReset_b = 1'b1;
    cyc(7);
    chk({secondaryTestReset_b, connectIndicator_b, secondaryDataOutEn}, 3'h6);
  endtask : testTestReset

  task automatic testBoardAddr();
    boardAddr = NEW_BOARD;
    cyc(6);
    sendAddr(BOARD);
    cyc(2);
    chk(rxOut.ackActive, 1'b0);
    sendAddr(NEW_BOARD);
    cyc(2);
    chk({rxOut.ackActive, connectIndicator_b}, 2'h3);
    pulseDone();
    cyc(3);
    chk(connectIndicator_b, 1'b0);
  endtask : testBoardAddr

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    rst_b = 1'b0;
    primaryTestReset_b = 1'b1;
    protocolBypassIn_b = 1'b1;
    secondaryDataIn = 1'b1;
    boardAddr = BOARD;
    rxIn = '0;
    rxIn.ackBit = 1'b1;
    repeat (12) @(negedge clock);
    rst_b = 1'b1;
    cyc(10);
    testPowerUp();
    testDeselect();
    testMatch();
    testMulticast();
    testBypass();
    testTestReset();
    testBoardAddr();
    end_sim();
  end

  // the whole sequence needs well under 2000 cycles
  initial begin
    #200us;
    fails++;
    end_sim();
  end
endmodule : tb
